/* logic/sarcs_fifo.sv */
// Parameterised flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sarcs_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic doWr;
  logic doRd;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  always_ff @(posedge clock)
  begin
    if (doWr)
    begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (doWr)
      begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRd)
      begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule : sarcs_fifo

/* logic/sarcs_pkg.sv */
// Shared constants and carriers for the conversion sequencer
package sarcs_pkg;
  localparam int RES_BITS = 14;
  localparam int CFG_BITS = 14;
  localparam logic [13:0] UNI_MAX = 14'h3fff;
  localparam logic [13:0] UNI_MIN = 14'h0000;
  localparam logic [13:0] BIP_MAX = 14'h1fff;
  localparam logic [13:0] BIP_MIN = 14'h2000;
  localparam logic [13:0] MSB_MASK = 14'h2000;
  localparam int INCC_LSB = 10;
  localparam logic [2:0] INCC_UNI_SE = 3'h7;
  localparam logic [2:0] INCC_UNI_COM = 3'h6;
  localparam logic [2:0] INCC_BIP_COM = 3'h2;
  // A decision must wait for the trial code register plus two comparator sync flops
  localparam int CONV_CLK_DIV = 3;
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_NS = 50;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] SETTLE_CYC4 = 4'(SETTLE_CYC);
  localparam logic [3:0] CONV_DIV4 = 4'(CONV_CLK_DIV);
  localparam int MIN_RATE_KSPS = 250;

  typedef struct packed {
    logic [13:0] code;
    logic [13:0] cfg;
  } sarcs_result_t;
endpackage : sarcs_pkg

/* logic/sarcs_sequencer.sv */
// SAR conversion sequencer: switch timing, binary search, coding, result FIFO
`timescale 1ns/1ps
// Behaviour
// - Convert strobe rising edge starts conversion
// - Open sample switches, then ground arrays
// - Fourteen-step binary search, MSB first
// - Finish: reacquire, latch code, flag done
// - Internal divider times bit decisions
// - Unipolar modes give straight binary
// - Bipolar modes give twos complement
// - Midscale and zero codes as ideal
// - Overrange saturates to largest code
// - Underrange saturates to smallest code
// - Host configures via 14-bit word
// - Result readable later, with its config
// - Result belongs to same conversion
// - Powered down between conversions
// - Strobe held high enables busy indication
// - Input config field picks coding
module sarcs_sequencer #(
  parameter int RES = sarcs_pkg::RES_BITS,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic convert_strobe,
  input wire logic comparatorHigh,
  input wire logic overRange,
  input wire logic underRange,
  input wire logic [sarcs_pkg::CFG_BITS-1:0] cfgWord,
  input wire logic cfgValid,
  output logic sample_switch_pos,
  output logic sample_switch_neg,
  output logic inputConnect,
  output logic [RES-1:0] dacSwitches,
  output logic poweredUp,
  output logic busyIndicator,
  output logic convDone,
  output logic [RES-1:0] resultCode,
  output logic [sarcs_pkg::CFG_BITS-1:0] resultCfg,
  output logic resultValid,
  input wire logic resultReady,
  output logic overflow
);
  typedef enum {SARCS_ACQ, SARCS_OPEN, SARCS_GROUND, SARCS_TRIAL, SARCS_DONE} sarcs_state_t;

  sarcs_state_t state;
  logic cnvMeta;
  logic cnvSync;
  logic cnvPrev;
  logic cmpMeta;
  logic cmpSync;
  logic ovMeta;
  logic ovSync;
  logic unMeta;
  logic unSync;
  logic [3:0] settleCnt;
  logic [3:0] divCnt;
  logic [RES-1:0] trialBit;
  logic [RES-1:0] sarReg;
  logic [sarcs_pkg::CFG_BITS-1:0] cfgActive;
  logic [sarcs_pkg::CFG_BITS-1:0] cfgConv;
  logic cnvRise;
  logic convTick;
  logic bipolar;
  logic [RES-1:0] next_code;
  logic fifoInReady;
  logic fifoOutValid;
  logic [27:0] fifoOutData;
  sarcs_pkg::sarcs_result_t pushWord;
  sarcs_pkg::sarcs_result_t popWord;
  logic [2:0] inCfg;

  // Pins from the analog side and the host are asynchronous to our clock
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnvMeta <= 1'b0;
      cnvSync <= 1'b0;
      cnvPrev <= 1'b0;
      cmpMeta <= 1'b0;
      cmpSync <= 1'b0;
      ovMeta <= 1'b0;
      ovSync <= 1'b0;
      unMeta <= 1'b0;
      unSync <= 1'b0;
    end
    else
    begin
      cnvMeta <= convert_strobe;
      cnvSync <= cnvMeta;
      cnvPrev <= cnvSync;
      cmpMeta <= comparatorHigh;
      cmpSync <= cmpMeta;
      ovMeta <= overRange;
      ovSync <= ovMeta;
      unMeta <= underRange;
      unSync <= unMeta;
    end
  end

  assign cnvRise = cnvSync && !cnvPrev;
  assign convTick = (divCnt == '0);

  // Config word applies from the next conversion start onward
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfgActive <= '0;
    end
    else if (cfgValid)
    begin
      cfgActive <= cfgWord;
    end
  end

  // Conversion-clock divider runs only in the trial state; it holds at reload otherwise
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      divCnt <= '0;
    end
    else if (state != SARCS_TRIAL || convTick)
    begin
      divCnt <= sarcs_pkg::CONV_DIV4;
    end
    else
    begin
      divCnt <= divCnt - 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= SARCS_ACQ;
      settleCnt <= '0;
      trialBit <= '0;
      sarReg <= '0;
      cfgConv <= '0;
    end
    else
    begin
      case (state)
        SARCS_ACQ:
        begin
          // A strobe during conversion is ignored; the host must wait
          if (cnvRise)
          begin
            state <= SARCS_OPEN;
            cfgConv <= cfgActive;
            settleCnt <= sarcs_pkg::SETTLE_CYC4;
          end
        end
        SARCS_OPEN:
        begin
          if (settleCnt == 4'h0)
          begin
            state <= SARCS_GROUND;
            settleCnt <= sarcs_pkg::SETTLE_CYC4;
          end
          else
          begin
            settleCnt <= settleCnt - 4'h1;
          end
        end
        SARCS_GROUND:
        begin
          if (settleCnt == 4'h0)
          begin
            state <= SARCS_TRIAL;
            trialBit <= sarcs_pkg::MSB_MASK;
            sarReg <= sarcs_pkg::MSB_MASK;
          end
          else
          begin
            settleCnt <= settleCnt - 4'h1;
          end
        end
        SARCS_TRIAL:
        begin
          if (convTick)
          begin
            // Comparator high means trial overshoots: drop this bit
            if (cmpSync)
            begin
              sarReg <= (sarReg & ~trialBit) | (trialBit >> 1);
            end
            else
            begin
              sarReg <= sarReg | (trialBit >> 1);
            end
            trialBit <= trialBit >> 1;
            if (trialBit[0])
            begin
              state <= SARCS_DONE;
            end
          end
        end
        SARCS_DONE:
        begin
          state <= SARCS_ACQ;
        end
        default:
        begin
          state <= SARCS_ACQ;
        end
      endcase
    end
  end

  assign inCfg = cfgConv[sarcs_pkg::INCC_LSB +: 3];
  // Pairs with 00x and common at half reference code as bipolar
  assign bipolar = (inCfg == sarcs_pkg::INCC_BIP_COM) || (inCfg[2:1] == 2'b00);

  always_comb
  begin
    if (ovSync)
    begin
      next_code = bipolar ? sarcs_pkg::BIP_MAX : sarcs_pkg::UNI_MAX;
    end
    else if (unSync)
    begin
      next_code = bipolar ? sarcs_pkg::BIP_MIN : sarcs_pkg::UNI_MIN;
    end
    else if (bipolar)
    begin
      next_code = sarReg ^ sarcs_pkg::MSB_MASK;
    end
    else
    begin
      next_code = sarReg;
    end
  end

  assign pushWord.code = next_code;
  assign pushWord.cfg = cfgConv;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sample_switch_pos <= 1'b1;
      sample_switch_neg <= 1'b1;
      inputConnect <= 1'b1;
      dacSwitches <= '0;
      poweredUp <= 1'b0;
      busyIndicator <= 1'b0;
      convDone <= 1'b0;
      overflow <= 1'b0;
    end
    else
    begin
      sample_switch_pos <= (state == SARCS_ACQ) && !cnvRise;
      sample_switch_neg <= (state == SARCS_ACQ) && !cnvRise;
      inputConnect <= (state == SARCS_ACQ) || (state == SARCS_OPEN && settleCnt != 4'h0);
      dacSwitches <= (state == SARCS_TRIAL) ? sarReg : '0;
      poweredUp <= (state != SARCS_ACQ) || cnvRise;
      // Busy flag shown while strobe stays high; drops on completion
      busyIndicator <= cnvSync && state != SARCS_ACQ && state != SARCS_DONE;
      convDone <= (state == SARCS_DONE);
      // Full FIFO loses the newest result rather than stall the converter
      overflow <= (state == SARCS_DONE) && !fifoInReady;
    end
  end

  sarcs_fifo #(
    .WIDTH(28),
    .DEPTH(FIFO_DEPTH)
  ) resultFifo (
    .clock(clock),
    .rst_b(rst_b),
    .inData(pushWord),
    .inValid(state == SARCS_DONE),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(resultReady && resultValid)
  );

  assign popWord = fifoOutData;

  // Registered output stage mirrors the FIFO head
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      resultCode <= '0;
      resultCfg <= '0;
      resultValid <= 1'b0;
    end
    else
    begin
      resultCode <= popWord.code;
      resultCfg <= popWord.cfg;
      resultValid <= fifoOutValid && !(resultReady && resultValid);
    end
  end
endmodule : sarcs_sequencer

/* tb/sar_conversion_sequencer_tb.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module sar_conversion_sequencer_tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic convert_strobe = 1'b0;
  logic overRange = 1'b0;
  logic underRange = 1'b0;
  logic cfgValid = 1'b0;
  logic resultReady = 1'b0;
  logic [13:0] cfgWord = 14'h0000;
  logic [13:0] level = 14'h0000;
  logic comparatorHigh, sample_switch_pos, sample_switch_neg, inputConnect;
  logic poweredUp, busyIndicator, convDone, resultValid, overflow, busySeen;
  logic [13:0] dacSwitches, resultCode, resultCfg;
  logic [13:0] qCode [$];
  logic [13:0] qCfg [$];
  logic [2:0] modes [7] = '{3'h7, 3'h6, 3'h4, 3'h5, 3'h2, 3'h0, 3'h1};
  logic [13:0] lv [4] = '{14'h2000, 14'h1fff, 14'h3fff, 14'h0000};
  int bad_count = 0;
  int total_checks = 0;
  int ovCount = 0;
  initial forever #12.5 clock = ~clock;
  sarcs_sequencer dut_u (.clock(clock), .rst_b(rst_b), .convert_strobe(convert_strobe),
    .comparatorHigh(comparatorHigh), .overRange(overRange), .underRange(underRange),
    .cfgWord(cfgWord), .cfgValid(cfgValid), .sample_switch_pos(sample_switch_pos),
    .sample_switch_neg(sample_switch_neg), .inputConnect(inputConnect), .dacSwitches(dacSwitches),
    .poweredUp(poweredUp), .busyIndicator(busyIndicator), .convDone(convDone),
    .resultCode(resultCode), .resultCfg(resultCfg), .resultValid(resultValid),
    .resultReady(resultReady), .overflow(overflow));
  sarcs_comparator_model far_u (.dacSwitches(dacSwitches), .heldLevel(level), .comparatorHigh(comparatorHigh));
  always @(posedge clock) if (overflow === 1'b1) ovCount++;
  always @(posedge clock) if (busyIndicator === 1'b1) busySeen = 1'b1;
  task summarize;
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task check(input string what, input logic [13:0] exp, input logic [13:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function logic [13:0] expCode(input logic [13:0] l, input logic [2:0] m, input logic ov, input logic un);
    logic bip;
    bip = (m == 3'h2) || (m[2:1] == 2'h0);
    if (ov) return bip ? sarcs_pkg::BIP_MAX : sarcs_pkg::UNI_MAX;
    if (un) return bip ? sarcs_pkg::BIP_MIN : sarcs_pkg::UNI_MIN;
    return bip ? l ^ sarcs_pkg::MSB_MASK : l;
  endfunction : expCode
  // Unheld strobes bounce mid-conversion; the design must ignore them
  task convert(input logic [13:0] l, input logic [2:0] m, input logic ov, input logic un, input logic hold);
    int n;
    @(negedge clock);
    cfgWord = 14'($urandom);
    cfgWord[12:10] = m;
    cfgValid = 1'b1;
    level = l;
    overRange = ov;
    underRange = un;
    @(negedge clock);
    cfgValid = 1'b0;
    busySeen = 1'b0;
    convert_strobe = 1'b1;
    qCode.push_back(expCode(l, m, ov, un));
    qCfg.push_back(cfgWord);
    n = 0;
    while (convDone !== 1'b1 && n < 200)
    begin
      @(negedge clock);
      n++;
      if (!hold) convert_strobe = (n >= 10 && n < 14);
    end
    check("done", 14'h0001, {13'h0, n < 200});
    if (hold) check("busy", 14'h0001, {13'h0, busySeen});
    convert_strobe = 1'b0;
    repeat (4) @(negedge clock);
    check("asleep", 14'h0000, {13'h0, poweredUp});
  endtask : convert
  task pop;
    int n;
    n = 0;
    while (resultValid !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    check("code", qCode.pop_front(), resultCode); // coded result
    check("cfg", qCfg.pop_front(), resultCfg); // paired config
    resultReady = 1'b1;
    @(negedge clock);
    resultReady = 1'b0;
  endtask : pop
  initial
  begin
    void'($urandom(90));
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
    for (int i = 0; i < 42; i++)
    begin
      convert(i < 28 ? lv[i / 7] : 14'($urandom), modes[i % 7], i / 7 == 4, i / 7 == 5, i[0]);
      pop();
    end
    for (int i = 0; i < 9; i++) convert(14'($urandom), modes[$urandom % 7], 1'b0, 1'b0, 1'b0);
    void'(qCode.pop_back());
    void'(qCfg.pop_back());
    check("overflow", 14'h0001, 14'(ovCount)); // ninth result dropped
    repeat (8) pop();
    repeat (3) @(negedge clock);
    check("drained", 14'h0000, {13'h0, resultValid});
    summarize();
  end
  initial
  begin
    #500000;
    bad_count++;
    summarize();
  end
endmodule : sar_conversion_sequencer_tb
bind sarcs_sequencer sarcs_sequencer_monitor #(.RES(RES)) mon_u (.clock(clock), .rst_b(rst_b),
  .sample_switch_pos(sample_switch_pos), .sample_switch_neg(sample_switch_neg), .inputConnect(inputConnect),
  .dacSwitches(dacSwitches), .poweredUp(poweredUp), .busyIndicator(busyIndicator), .convDone(convDone),
  .resultCode(resultCode), .resultCfg(resultCfg), .resultValid(resultValid), .resultReady(resultReady),
  .overflow(overflow));

/* tb/sarcs_comparator_model.sv */
// Comparator and held-sample model facing the capacitor arrays
`timescale 1ns/1ps
module sarcs_comparator_model (
  input wire logic [13:0] dacSwitches,
  input wire logic [13:0] heldLevel,
  output logic comparatorHigh
);
  // Held level stands in for the captured charge
  assign comparatorHigh = dacSwitches > heldLevel;
endmodule : sarcs_comparator_model

/* tb/sarcs_sequencer_monitor.sv */
// Port checker for the conversion sequencer
`timescale 1ns/1ps
module sarcs_sequencer_monitor #(
  parameter int RES = 14
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sample_switch_pos,
  input wire logic sample_switch_neg,
  input wire logic inputConnect,
  input wire logic [RES-1:0] dacSwitches,
  input wire logic poweredUp,
  input wire logic busyIndicator,
  input wire logic convDone,
  input wire logic [RES-1:0] resultCode,
  input wire logic [sarcs_pkg::CFG_BITS-1:0] resultCfg,
  input wire logic resultValid,
  input wire logic resultReady,
  input wire logic overflow
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  property p_done;
    convDone |=> !convDone;
  endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle");
  property p_open;
    $fell(inputConnect) |-> !sample_switch_pos && !sample_switch_neg && !$past(sample_switch_pos);
  endproperty
  a_open: assert property (p_open) else $error("arrays grounded before switches opened");
  // Window covers both settle phases plus fourteen four-cycle decisions
  property p_time;
    $rose(poweredUp) |-> ##[60:66] convDone;
  endproperty
  a_time: assert property (p_time) else $error("conversion length off");
  property p_reacq;
    convDone |-> ##[0:3] (sample_switch_pos && sample_switch_neg && inputConnect);
  endproperty
  a_reacq: assert property (p_reacq) else $error("no return to acquisition");
  property p_busy;
    busyIndicator |-> poweredUp;
  endproperty
  a_busy: assert property (p_busy) else $error("busy outside conversion");
  property p_idle;
    !poweredUp |-> dacSwitches == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("trial code while idle");
  property p_msb;
    dacSwitches != '0 && $past(dacSwitches) == '0 |-> dacSwitches == sarcs_pkg::MSB_MASK;
  endproperty
  a_msb: assert property (p_msb) else $error("first trial not the top bit");
  property p_hold;
    resultValid && !resultReady |=> resultValid && $stable(resultCode) && $stable(resultCfg);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed before taken");
  property p_sleep;
    convDone |-> ##[0:3] !poweredUp;
  endproperty
  a_sleep: assert property (p_sleep) else $error("still powered after done");
  c_done: cover property (convDone);
  c_busy: cover property (busyIndicator);
  c_ovf: cover property (overflow);
endmodule : sarcs_sequencer_monitor
